//--- dpc_map.svh
// offsets, field positions, reset values and timing counts of the pot control
//
// What this block does
// - address first=0/second=1 picks channel one, 1/1 two
// - address and data bits arrive LSB first
// - frame decoding waits for a logic one start
// - serial input sampled on link clock rise, select high
// - frames and output only while select high
// - loaded wiper value holds while select high
// - select low reloads stored values, output released
// - select filtered against glitches shorter than 30 ns
// - outgoing bits change on link clock rise
// - state kept while link clock stands still
// - power-on loads wipers from stored values
// - each wiper is eight bits, 256 steps
// - store: busy low, input ignored, no output
// - output updates after last bit, ready two later
// - after address, addressed value shifts out LSB first
`ifndef DPC_MAP_SVH
`define DPC_MAP_SVH
// ****************************************************************
// register map (byte addresses)
// ****************************************************************
`define DPC_OFS_WIPER 8'h00
`define DPC_OFS_STORED 8'h04
`define DPC_OFS_CTRL 8'h08
`define DPC_OFS_STATUS 8'h0C
`define DPC_CTRL_LINK_EN 0
`define DPC_STAT_BUSY 0
`define DPC_STAT_SEL 1
`define DPC_STAT_FRAME 2
`define DPC_CTRL_RESET 1'b1
// ****************************************************************
// reset values and timing
// ****************************************************************
`define DPC_NV_RESET 8'h80
`define DPC_CLK_NS 10
`define DPC_FILT_NS 30
`define DPC_FILT_CYC ((`DPC_FILT_NS + `DPC_CLK_NS - 1) / `DPC_CLK_NS)
`define DPC_BUSY_NS 4000000
`define DPC_BUSY_CYC (`DPC_BUSY_NS / `DPC_CLK_NS)
`define DPC_BUSY_W 20
`endif

//--- dpc_pkg.sv
// types shared by the pot control modules
package dpc_pkg;
   typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_DATA, ST_GAP} dpc_state_t;
   typedef logic [7:0] dpc_wiper_t;
endpackage

//--- dpc_nv_if.sv
// link between frame logic and non-volatile store
`timescale 1ns/100ps
interface dpc_nv_if;
   logic start;
   logic chan;
   dpc_pkg::dpc_wiper_t data;
   logic busy;
   dpc_pkg::dpc_wiper_t nv_one;
   dpc_pkg::dpc_wiper_t nv_two;
   modport store (input start, input chan, input data,
      output busy, output nv_one, output nv_two);
   modport ctl (output start, output chan, output data,
      input busy, input nv_one, input nv_two);
endinterface

//--- dpc_sync.sv
// two-stage synchroniser with optional stability filter
`timescale 1ns/100ps
module dpc_sync #(
   parameter int FILT = 1,
   parameter bit RST = 1'b0
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_d,
   output logic o_q
);
   logic s1_ff;
   logic s2_ff;
   logic q_ff;
   logic [2:0] cnt_ff;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s1_ff <= RST;
         s2_ff <= RST;
      end else begin
         s1_ff <= i_d;
         s2_ff <= s1_ff;
      end
   end

   // a level must stand FILT cycles before it is believed
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         q_ff <= RST;
         cnt_ff <= 3'h0;
      end else if (s2_ff == q_ff) begin
         cnt_ff <= 3'h0;
      end else if (cnt_ff == 3'(FILT - 1)) begin
         q_ff <= s2_ff;
         cnt_ff <= 3'h0;
      end else begin
         cnt_ff <= cnt_ff + 3'h1;
      end
   end

   assign o_q = q_ff;

   a_filter_hold: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      $changed(q_ff) |-> $past(cnt_ff) == 3'(FILT - 1))
      else $error("filter output moved before its count ran out");
endmodule // dpc_sync

//--- dpc_nvm.sv
// non-volatile wiper store with busy timer
`timescale 1ns/100ps
`include "dpc_map.svh"
module dpc_nvm #(
   parameter int BUSY_CYC = `DPC_BUSY_CYC
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   dpc_nv_if.store nv
);
   dpc_pkg::dpc_wiper_t mem_ff [2];
   logic busy_ff;
   logic [`DPC_BUSY_W-1:0] tmr_ff;

   // stored cells are written at the start; the timer models the cycle
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         mem_ff[0] <= `DPC_NV_RESET;
         mem_ff[1] <= `DPC_NV_RESET;
      end else if (nv.start && !busy_ff) begin
         mem_ff[nv.chan] <= nv.data;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         busy_ff <= 1'b0;
         tmr_ff <= '0;
      end else if (nv.start && !busy_ff) begin
         busy_ff <= 1'b1;
         tmr_ff <= `DPC_BUSY_W'(BUSY_CYC - 1);
      end else if (busy_ff) begin
         if (tmr_ff == '0) begin
            busy_ff <= 1'b0;
         end else begin
            tmr_ff <= tmr_ff - `DPC_BUSY_W'(1);
         end
      end
   end

   assign nv.busy = busy_ff;
   assign nv.nv_one = mem_ff[0];
   assign nv.nv_two = mem_ff[1];

   a_busy_starts: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      nv.start && !busy_ff |=> busy_ff [*2])
      else $error("store did not raise busy");
endmodule // dpc_nvm

//--- dpc_top.sv
// serial pot control: link decoder, wipers and AHB-Lite registers
//
// The AHB-Lite slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`include "dpc_map.svh"
module dpc_top #(
   parameter int P_BUSY_CYC = `DPC_BUSY_CYC
) (
   input wire logic i_mclk,
   input wire logic i_resetn,
   input wire logic i_link_clk,
   input wire logic i_select,
   input wire logic i_serial_in,
   input wire logic i_store_request,
   output logic o_serial_out,
   output logic o_serial_out_oe,
   output logic o_write_done_flag,
   output logic [7:0] o_channel_one_output,
   output logic [7:0] o_channel_two_output,
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic [31:0] o_hrdata,
   output logic o_hreadyout,
   output logic o_hresp
);
   // ****************************************************************
   // reset release and pin synchronisers
   // ****************************************************************
   logic rst1_ff;
   logic rst_n;
   logic lclk_s;
   logic sel_s;
   logic din_s;
   logic store_request_s;

   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         rst1_ff <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst1_ff <= 1'b1;
         rst_n <= rst1_ff;
      end
   end

   dpc_sync #(.FILT(1), .RST(1'b0)) u_sync_clk (.i_clk(i_mclk),
      .i_rst_n(rst_n), .i_d(i_link_clk), .o_q(lclk_s));
   // select acts as a reset, so spikes must not reach it
   dpc_sync #(.FILT(`DPC_FILT_CYC), .RST(1'b0)) u_sync_sel (.i_clk(i_mclk),
      .i_rst_n(rst_n), .i_d(i_select), .o_q(sel_s));
   dpc_sync #(.FILT(1), .RST(1'b0)) u_sync_din (.i_clk(i_mclk),
      .i_rst_n(rst_n), .i_d(i_serial_in), .o_q(din_s));
   dpc_sync #(.FILT(1), .RST(1'b0)) u_sync_store_request (.i_clk(i_mclk),
      .i_rst_n(rst_n), .i_d(i_store_request), .o_q(store_request_s));

   dpc_nv_if nv ();
   dpc_nvm #(.BUSY_CYC(P_BUSY_CYC)) u_nvm (.i_clk(i_mclk), .i_rst_n(rst_n),
      .nv(nv.store));

   // ****************************************************************
   // link edge detect and frame state
   // ****************************************************************
   logic lclk_d_ff;
   logic rise;
   logic link_en_ff;
   logic active;
   dpc_pkg::dpc_state_t state_ff;
   logic [2:0] cnt_ff;
   logic a_first_ff;
   logic a_second_ff;
   dpc_pkg::dpc_wiper_t sh_ff;
   dpc_pkg::dpc_wiper_t new_data;
   dpc_pkg::dpc_wiper_t wip_one_ff;
   dpc_pkg::dpc_wiper_t wip_two_ff;
   dpc_pkg::dpc_wiper_t addr_val;
   logic addr_ok;
   logic load;
   logic dout_ff;
   logic start_ff;
   logic chan_ff;
   dpc_pkg::dpc_wiper_t sdata_ff;

   always_ff @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
         lclk_d_ff <= 1'b0;
      end else begin
         lclk_d_ff <= lclk_s;
      end
   end

   // a stopped link clock simply makes no edges; nothing times out
   assign rise = lclk_s && !lclk_d_ff;
   assign active = sel_s && link_en_ff && !nv.busy;
   assign addr_ok = a_second_ff;
   assign addr_val = a_first_ff ? wip_two_ff : wip_one_ff;
   assign new_data = {din_s, sh_ff[7:1]};
   assign load = rise && active && state_ff == dpc_pkg::ST_DATA &&
      cnt_ff == 3'h7 && addr_ok;

   always_ff @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= dpc_pkg::ST_IDLE;
         cnt_ff <= 3'h0;
      end else if (!active) begin
         state_ff <= dpc_pkg::ST_IDLE;
         cnt_ff <= 3'h0;
      end else if (rise) begin
         unique case (state_ff)
            dpc_pkg::ST_IDLE: begin
               if (din_s) begin
                  state_ff <= dpc_pkg::ST_ADDR;
               end
               cnt_ff <= 3'h0;
            end
            dpc_pkg::ST_ADDR: begin
               if (cnt_ff == 3'h1) begin
                  state_ff <= dpc_pkg::ST_DATA;
                  cnt_ff <= 3'h0;
               end else begin
                  cnt_ff <= cnt_ff + 3'h1;
               end
            end
            dpc_pkg::ST_DATA: begin
               if (cnt_ff == 3'h7) begin
                  state_ff <= dpc_pkg::ST_GAP;
               end
               cnt_ff <= cnt_ff + 3'h1;
            end
            dpc_pkg::ST_GAP: begin
               state_ff <= dpc_pkg::ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
         a_first_ff <= 1'b0;
         a_second_ff <= 1'b0;
      end else if (rise && active && state_ff == dpc_pkg::ST_ADDR) begin
         if (cnt_ff == 3'h0) begin
            a_first_ff <= din_s;
         end else begin
            a_second_ff <= din_s;
         end
      end
   end

   // read-back is destructive: the old value leaves as the new one enters
   always_ff @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
         sh_ff <= 8'h00;
         dout_ff <= 1'b0;
      end else if (rise && active) begin
         if (state_ff == dpc_pkg::ST_ADDR && cnt_ff == 3'h1) begin
            sh_ff <= din_s ? (a_first_ff ? wip_two_ff : wip_one_ff) : 8'h00;
            dout_ff <= din_s ? (a_first_ff ? wip_two_ff[0] :
               wip_one_ff[0]) : 1'b0;
         end else if (state_ff == dpc_pkg::ST_DATA) begin
            sh_ff <= new_data;
            dout_ff <= addr_ok && cnt_ff != 3'h7 ? sh_ff[1] : 1'b0;
         end
      end
   end

   // power-on and select low both restore the stored settings
   always_ff @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
         wip_one_ff <= `DPC_NV_RESET;
         wip_two_ff <= `DPC_NV_RESET;
      end else if (!sel_s) begin
         wip_one_ff <= nv.nv_one;
         wip_two_ff <= nv.nv_two;
      end else if (load) begin
         if (a_first_ff) begin
            wip_two_ff <= new_data;
         end else begin
            wip_one_ff <= new_data;
         end
      end
   end

   // store request is judged at the edge after the last data bit
   always_ff @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
         start_ff <= 1'b0;
         chan_ff <= 1'b0;
         sdata_ff <= 8'h00;
      end else begin
         start_ff <= rise && active && state_ff == dpc_pkg::ST_GAP &&
            store_request_s && addr_ok;
         if (load) begin
            chan_ff <= a_first_ff;
            sdata_ff <= new_data;
         end
      end
   end

   assign nv.start = start_ff;
   assign nv.chan = chan_ff;
   assign nv.data = sdata_ff;

   // ****************************************************************
   // pin outputs
   // ****************************************************************
   always_ff @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
         o_serial_out <= 1'b0;
         o_serial_out_oe <= 1'b0;
         o_write_done_flag <= 1'b1;
         o_channel_one_output <= `DPC_NV_RESET;
         o_channel_two_output <= `DPC_NV_RESET;
      end else begin
         o_serial_out <= dout_ff;
         o_serial_out_oe <= active;
         o_write_done_flag <= !nv.busy;
         o_channel_one_output <= wip_one_ff;
         o_channel_two_output <= wip_two_ff;
      end
   end

   // ****************************************************************
   // AHB-Lite register slave, zero wait states
   // ****************************************************************
   logic wr_pend_ff;
   logic [7:0] wr_addr_ff;
   logic [31:0] rd_val;
   logic [31:0] ctrl_now;

   assign ctrl_now = (wr_pend_ff && wr_addr_ff == `DPC_OFS_CTRL) ?
      {31'h0, i_hwdata[`DPC_CTRL_LINK_EN]} : {31'h0, link_en_ff};

   always_comb begin
      rd_val = 32'h0;
      unique case (i_haddr[7:0])
         `DPC_OFS_WIPER: rd_val = {16'h0, wip_two_ff, wip_one_ff};
         `DPC_OFS_STORED: rd_val = {16'h0, nv.nv_two, nv.nv_one};
         `DPC_OFS_CTRL: rd_val = ctrl_now;
         `DPC_OFS_STATUS: rd_val = {29'h0, state_ff != dpc_pkg::ST_IDLE,
            sel_s, nv.busy};
         default: rd_val = 32'h0;
      endcase
   end

   always_ff @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
         wr_pend_ff <= 1'b0;
         wr_addr_ff <= 8'h00;
         o_hrdata <= 32'h0;
         o_hreadyout <= 1'b1;
         o_hresp <= 1'b0;
      end else begin
         o_hreadyout <= 1'b1;
         o_hresp <= 1'b0;
         wr_pend_ff <= i_hsel && i_htrans[1] && i_hready && i_hwrite;
         if (i_hsel && i_htrans[1] && i_hready) begin
            wr_addr_ff <= i_haddr[7:0];
            o_hrdata <= i_hwrite ? 32'h0 : rd_val;
         end
      end
   end

   always_ff @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
         link_en_ff <= `DPC_CTRL_RESET;
      end else if (wr_pend_ff && wr_addr_ff == `DPC_OFS_CTRL) begin
         link_en_ff <= i_hwdata[`DPC_CTRL_LINK_EN];
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   a_sel_tristate: assert property (
      @(posedge i_mclk) disable iff (!rst_n)
      !sel_s |=> !o_serial_out_oe)
      else $error("output driven with select low");
   a_busy_quiet: assert property (
      @(posedge i_mclk) disable iff (!rst_n)
      nv.busy |=> !o_serial_out_oe && !o_write_done_flag)
      else $error("output driven or flag high during store");
   a_sel_reload: assert property (
      @(posedge i_mclk) disable iff (!rst_n)
      !sel_s |=> wip_one_ff == $past(nv.nv_one) &&
      wip_two_ff == $past(nv.nv_two))
      else $error("wipers not restored on select low");
   a_wiper_hold: assert property (
      @(posedge i_mclk) disable iff (!rst_n)
      sel_s && !load |=> $stable(wip_one_ff) && $stable(wip_two_ff))
      else $error("wiper changed without a frame");
   a_need_start: assert property (
      @(posedge i_mclk) disable iff (!rst_n)
      state_ff == dpc_pkg::ST_IDLE && !(rise && din_s) |=>
      state_ff == dpc_pkg::ST_IDLE)
      else $error("frame began without a start bit");
   a_load_output: assert property (
      @(posedge i_mclk) disable iff (!rst_n)
      load && !a_first_ff && sel_s |-> ##2 o_channel_one_output ==
      $past(new_data, 2))
      else $error("channel one output missed its new value");
   a_bad_addr: assert property (
      @(posedge i_mclk) disable iff (!rst_n)
      sel_s && state_ff == dpc_pkg::ST_DATA && !a_second_ff |=>
      $stable(wip_one_ff) && $stable(wip_two_ff))
      else $error("wiper loaded from an unknown address");
   a_readback_lsb: assert property (
      @(posedge i_mclk) disable iff (!rst_n)
      rise && active && state_ff == dpc_pkg::ST_ADDR && cnt_ff == 3'h1 &&
      din_s && !a_first_ff |-> ##2 o_serial_out == $past(wip_one_ff[0], 2))
      else $error("first read-back bit not the stored lsb");
   a_gap_after: assert property (
      @(posedge i_mclk) disable iff (!rst_n)
      load |=> state_ff == dpc_pkg::ST_GAP || !active)
      else $error("no gap after the last data bit");

   c_load_one: cover property (@(posedge i_mclk) disable iff (!rst_n)
      load && !a_first_ff);
   c_load_two: cover property (@(posedge i_mclk) disable iff (!rst_n)
      load && a_first_ff);
   c_store: cover property (@(posedge i_mclk) disable iff (!rst_n)
      start_ff);
   c_sel_drop: cover property (@(posedge i_mclk) disable iff (!rst_n)
      $fell(sel_s));
endmodule // dpc_top

//--- dpc_host_model.sv
// host-side model that drives the serial pot control link
`timescale 1ns/100ps
module dpc_host_model (
   input wire logic i_clk,
   input wire logic i_serial_out,
   input wire logic i_serial_out_oe,
   input wire logic i_write_done_flag,
   output logic o_link_clk,
   output logic o_select,
   output logic o_serial_in,
   output logic o_store_request
);
   // half a 160 ns link period, in system clocks
   localparam int HALF = 8;
   int busy_cyc;
   int oe_busy;
   initial begin
      o_link_clk <= 1'b0;
      o_select <= 1'b0;
      o_serial_in <= 1'b0;
      o_store_request <= 1'b0;
      busy_cyc = 0;
      oe_busy = 0;
   end
   // ****************************************************************
   // link clock: 160 ns period, data set up half a period ahead
   // ****************************************************************
   // pins move only just after a system clock edge, never on it
   task automatic wait_clk(input int n);
      repeat (n) @(posedge i_clk);
   endtask
   task automatic tick(input logic b);
      o_serial_in <= b;
      wait_clk(HALF);
      o_link_clk <= 1'b1;
      wait_clk(HALF);
      o_link_clk <= 1'b0;
   endtask
   task automatic sel(input logic v);
      o_select <= v;
      wait_clk(30);
   endtask
   // 20 ns low pulse, well under the select filter
   task automatic glitch();
      o_select <= 1'b0;
      wait_clk(2);
      o_select <= 1'b1;
      wait_clk(30);
   endtask
   // ****************************************************************
   // one frame: start, address, data, then gap or store cycle
   // ****************************************************************
   task automatic frame(input int lead, input logic a0, input logic a1,
      input logic [7:0] d, input logic st, output logic [7:0] rb);
      logic [10:0] bits;
      bits = {d, a1, a0, 1'b1};
      rb = 8'h00;
      repeat (lead) tick(1'b0);
      for (int i = 0; i < 11; i++) begin
         o_serial_in <= bits[i];
         if (i == 3) o_store_request <= st;
         wait_clk(HALF);
         if (i >= 3) rb[i-3] = i_serial_out;
         o_link_clk <= 1'b1;
         wait_clk(HALF);
         o_link_clk <= 1'b0;
      end
      tick(1'b0);
      o_store_request <= 1'b0;
      busy_cyc = 0;
      oe_busy = 0;
      if (st) begin
         // clock kept running until ready; early ones must be ignored
         for (int k = 0; k < 40; k++) begin
            if (k > 3 && i_write_done_flag === 1'b1) break;
            tick(k < 2);
            if (i_write_done_flag === 1'b0) begin
               busy_cyc++;
               if (i_serial_out_oe !== 1'b0) oe_busy++;
            end
         end
      end else begin
         tick(1'b0);
      end
      // data line inverted, clock stands low until the next frame
      o_serial_in <= ~o_serial_in;
      wait_clk(1);
   endtask
endmodule // dpc_host_model

//--- tb.sv
// self-checking bench of the serial pot control
`timescale 1ns/100ps
module tb;
   logic i_mclk = 1'b0;
   logic i_resetn = 1'b0;
   logic link_clk, select, serial_in, store_req;
   logic serial_out, serial_out_oe, write_done;
   logic [7:0] ch_one, ch_two;
   logic hsel;
   logic [31:0] haddr;
   logic [1:0] htrans;
   logic hwrite;
   logic [2:0] hsize;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic hreadyout, hresp;
   logic [15:0] ch_last = 16'h8080;
   logic [15:0] exp_q[$];
   int errors = 0;
   int checked = 0;
   integer seed = 32'hA8E18EB6;
   always #5 i_mclk = ~i_mclk;
   dpc_top #(.P_BUSY_CYC(50)) dut (.i_mclk(i_mclk), .i_resetn(i_resetn),
      .i_link_clk(link_clk), .i_select(select), .i_serial_in(serial_in),
      .i_store_request(store_req), .o_serial_out(serial_out),
      .o_serial_out_oe(serial_out_oe), .o_write_done_flag(write_done),
      .o_channel_one_output(ch_one), .o_channel_two_output(ch_two),
      .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
      .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
      .i_hready(hreadyout), .o_hrdata(hrdata),
      .o_hreadyout(hreadyout), .o_hresp(hresp));
   dpc_host_model host (.i_clk(i_mclk), .i_serial_out(serial_out),
      .i_serial_out_oe(serial_out_oe), .i_write_done_flag(write_done),
      .o_link_clk(link_clk), .o_select(select), .o_serial_in(serial_in),
      .o_store_request(store_req));
   // ****************************************************************
   // reporting
   // ****************************************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
      input string what);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic test_end(input string name);
      $display("test %s finished", name);
   endtask
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      #300000;
      errors++;
      $display("CHECK FAILED %0t run timed out", $time);
      finish_test();
   end
   // ****************************************************************
   // AHB-Lite master, single word transfers
   // ****************************************************************
   task automatic wait_ready();
      int n;
      n = 0;
      do begin
         @(posedge i_mclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (n >= 50) begin
         errors++;
         $display("CHECK FAILED %0t bus never ready", $time);
         finish_test();
      end
   endtask
   task automatic ahb(input logic wr, input logic [31:0] a,
      input logic [31:0] wd, output logic [31:0] rd);
      @(posedge i_mclk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'b10;
      hwrite <= wr;
      wait_ready();
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= wd;
      wait_ready();
      rd = hrdata;
   endtask
   task automatic ahb_rd(input logic [31:0] a, input logic [31:0] exp);
      logic [31:0] r;
      ahb(1'b0, a, 32'h00000000, r);
      chk(r, exp, "register read");
      chk(hresp, 1'b0, "bus response");
   endtask
   task automatic ahb_wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] r;
      ahb(1'b1, a, d, r);
   endtask
   function automatic logic [7:0] pick(input logic [7:0] a,
      input logic [7:0] b);
      logic [7:0] v;
      v = 8'($random(seed));
      while (v === a || v === b) v = v + 8'h01;
      return v;
   endfunction
   // every change of the channel outputs must have been announced
   always @(posedge i_mclk) begin
      if (i_resetn && {ch_two, ch_one} !== ch_last) begin
         ch_last <= {ch_two, ch_one};
         if (exp_q.size() == 0) begin
            errors++;
            $display("CHECK FAILED %0t unexpected output change", $time);
         end else begin
            chk({ch_two, ch_one}, exp_q.pop_front(), "outputs");
         end
      end
   end
   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      logic [7:0] rb, d1, d2, d3;
      hsel <= 1'b0;
      haddr <= 32'h00000000;
      htrans <= 2'b00;
      hwrite <= 1'b0;
      hsize <= 3'b010;
      hwdata <= 32'h00000000;
      repeat (2) @(posedge i_mclk);
      i_resetn <= 1'b1;
      repeat (10) @(posedge i_mclk);
      ahb_rd(32'h00, 32'h00008080);
      ahb_rd(32'h04, 32'h00008080);
      ahb_rd(32'h08, 32'h00000001);
      ahb_rd(32'h10, 32'h00000000);
      chk(write_done, 1'b1, "ready after reset");
      chk(serial_out_oe, 1'b0, "output off");
      test_end("reset");
      host.sel(1'b1);
      chk(serial_out_oe, 1'b1, "output on");
      ahb_rd(32'h0C, 32'h00000002);
      d1 = pick(8'h80, 8'h80);
      exp_q.push_back({8'h80, d1});
      host.frame(2, 1'b0, 1'b1, d1, 1'b0, rb);
      chk(rb, 8'h80, "read back one");
      d2 = pick(8'h80, d1);
      exp_q.push_back({d2, d1});
      host.frame(0, 1'b1, 1'b1, d2, 1'b0, rb);
      chk(rb, 8'h80, "read back two");
      repeat (100) @(posedge i_mclk);
      d3 = pick(d1, 8'h80);
      exp_q.push_back({d2, d3});
      host.frame(0, 1'b0, 1'b1, d3, 1'b0, rb);
      chk(rb, d1, "held value");
      ahb_rd(32'h00, {16'h0000, d2, d3});
      test_end("load");
      for (int i = 0; i < 2; i++) begin
         host.frame(0, i[0], 1'b0, pick(d2, d3), 1'b0, rb);
         chk(rb, 8'h00, "bad address read");
      end
      ahb_rd(32'h00, {16'h0000, d2, d3});
      host.glitch();
      ahb_rd(32'h00, {16'h0000, d2, d3});
      test_end("refused");
      exp_q.push_back(16'h8080);
      host.sel(1'b0);
      chk(serial_out_oe, 1'b0, "output released");
      host.frame(0, 1'b0, 1'b1, 8'h55, 1'b0, rb);
      ahb_rd(32'h00, 32'h00008080);
      test_end("deselect");
      host.sel(1'b1);
      d1 = pick(8'h80, d2);
      exp_q.push_back({d1, 8'h80});
      host.frame(0, 1'b1, 1'b1, d1, 1'b1, rb);
      chk(host.busy_cyc != 0, 1'b1, "busy seen");
      chk(host.oe_busy, 0, "no output while busy");
      chk(write_done, 1'b1, "ready again");
      ahb_rd(32'h04, {16'h0000, d1, 8'h80});
      d2 = pick(d1, 8'h80);
      exp_q.push_back({d2, 8'h80});
      host.frame(0, 1'b1, 1'b1, d2, 1'b0, rb);
      chk(rb, d1, "frame after store");
      exp_q.push_back({d1, 8'h80});
      host.sel(1'b0);
      test_end("store");
      ahb_wr(32'h08, 32'h00000000);
      ahb_rd(32'h08, 32'h00000000);
      host.sel(1'b1);
      chk(serial_out_oe, 1'b0, "link disabled");
      host.frame(0, 1'b0, 1'b1, 8'h3C, 1'b0, rb);
      ahb_rd(32'h00, {16'h0000, d1, 8'h80});
      ahb_wr(32'h08, 32'h00000001);
      ahb_rd(32'h08, 32'h00000001);
      host.sel(1'b0);
      repeat (20) @(posedge i_mclk);
      chk(exp_q.size(), 0, "pending output changes");
      test_end("disable");
      finish_test();
   end
endmodule // tb
